// file: testbench/jip_host_model.sv
`timescale 1ns/10ps
module jip_host_model (
  input  wire logic clk_i,
  input  wire logic tdo_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // One test clock of 16 system clocks, 160 ns.
  // Callers arrive just after a system clock edge.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o <= tms;
    tdi_o <= tdi;
    repeat (8) @(posedge clk_i);
    tdo = tdo_i;
    tck_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    tck_o <= 1'b0;
  endtask
  task automatic idle(input int n);
    logic b;
    repeat (n) step(1'b0, 1'b1, b);
  endtask
  task automatic reset_tap();
    logic b;
    repeat (5) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
  // Full scan from idle back to idle, LSB first.
  task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b1, b);
    if (is_ir) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
endmodule

// file: testbench/jip_isp_assertions.sv
`timescale 1ns/10ps
module jip_isp_assertions #(
  parameter int unsigned IO_W        = 8,
  parameter int unsigned INIT_CYCLES = 20
) (
  // System.
  input wire logic            clk_sys_i,
  input wire logic            rst_i,
  // Observed pins.
  input wire logic            tck_i,
  input wire logic            tdo_o,
  input wire logic            tdo_oe_o,
  input wire logic [IO_W-1:0] core_out_i,
  input wire logic [IO_W-1:0] pin_out_o,
  input wire logic            isp_mode_o,
  input wire logic            init_done_o
);
  logic [31:0] wait_reg;
  logic [31:0] wait_next;
  // Counts cycles spent waiting for initialization.
  always_comb begin
    wait_next = wait_reg + 32'h1;
    if (init_done_o || isp_mode_o) wait_next = 32'h0;
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) wait_reg <= 32'h0;
    else wait_reg <= wait_next;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_oe_on_fall: assert property ($changed(tdo_oe_o) |-> !$past(tck_i, 2) && !tck_i)
    else $error("TDO enable moved outside a low test clock");
  a_tdo_on_fall: assert property ($changed(tdo_o) |-> !$past(tck_i, 2) && !tck_i)
    else $error("TDO moved outside a low test clock");
  a_isp_on_rise: assert property ($changed(isp_mode_o) |-> $past(tck_i, 2) && tck_i)
    else $error("ISP mode moved outside a high test clock");
  a_pins_normal: assert property (!$past(isp_mode_o) && !$past(rst_i)
    |-> pin_out_o == $past(core_out_i))
    else $error("User pins do not follow core outputs");
  a_pins_held: assert property (isp_mode_o && $past(isp_mode_o, 2) |-> $stable(pin_out_o))
    else $error("User pins moved during ISP");
  a_init_low: assert property (isp_mode_o |-> !init_done_o)
    else $error("Init done during ISP");
  a_init_within: assert property (wait_reg <= INIT_CYCLES + 4)
    else $error("Initialization took too long");
  a_reset_quiet: assert property ($fell(rst_i)
    |-> !isp_mode_o && !tdo_oe_o && !init_done_o && pin_out_o == '0)
    else $error("Outputs not at reset values");
endmodule

// file: testbench/tb.sv
`timescale 1ns/10ps
module tb;
  logic        clk_sys_i;
  logic        rst_i;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo_o;
  logic        tdo_oe_o;
  logic        isp_mode_o;
  logic        init_done_o;
  logic [7:0]  core_out_i;
  logic [7:0]  pin_in_i;
  logic [7:0]  pin_out_o;
  logic [31:0] q;
  int          bad_count;
  int          num_checks;
  // Rows hold {data, address}; a verify must return the same value.
  logic [19:0] rows[3] = '{20'h12340, 20'hfffff, 20'ha55a5};
  // Scaled idle counts; the device acts on the first idle edge.
  localparam int ERASE_N = 4;
  localparam int PROG_N  = 3;
  localparam int VER_N   = 2;
  // The TDO line has a pull-up when released.
  wire logic tdo_w = tdo_oe_o ? tdo_o : 1'b1;
  jip_host_model host (.clk_i(clk_sys_i), .tdo_i(tdo_w), .tck_o(tck), .tms_o(tms),
                       .tdi_o(tdi));
  jip_isp_top #(.IO_W(8), .ROW_W(16), .ADDR_W(4), .INIT_CYCLES(20)) uut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .core_out_i(core_out_i), .pin_in_i(pin_in_i),
    .pin_out_o(pin_out_o), .isp_mode_o(isp_mode_o), .init_done_o(init_done_o));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic ir(input logic [4:0] code);
    host.scan(1'b1, 5, 32'(code), q);
    check("ir capture", 32'(q[4:0]), 32'(jip_pkg::IR_CAPTURE));
  endtask
  task automatic program_row(input logic [19:0] row);
    ir(jip_pkg::INS_PROGRAM);
    host.scan(1'b0, 20, 32'(row), q);
    host.idle(PROG_N);
  endtask
  task automatic verify_row(input logic [19:0] row);
    ir(jip_pkg::INS_VERIFY);
    host.scan(1'b0, 20, 32'(row[3:0]), q);
    host.idle(VER_N);
    host.scan(1'b0, 20, 32'(row[3:0]), q);
    check("row", 32'(q[19:0]), 32'(row));
  endtask
  initial begin
    repeat (50000) @(posedge clk_sys_i);
    bad_count++;
    finish_test();
  end
  initial begin
    rst_i = 1'b1;
    core_out_i = 8'h3c;
    pin_in_i = 8'h96;
    bad_count = 0;
    num_checks = 0;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    host.reset_tap();
    program_row(20'hbeef3);
    check("pins normal", 32'(pin_out_o), 32'h3c);
    ir(jip_pkg::INS_PRELOAD);
    host.scan(1'b0, 8, 32'ha5, q);
    check("sample", 32'(q[7:0]), 32'h96);
    ir(jip_pkg::INS_ENABLE);
    core_out_i <= 8'h0f;
    repeat (2) @(posedge clk_sys_i);
    check("isp on", 32'(isp_mode_o), 32'h1);
    check("pins held", 32'(pin_out_o), 32'ha5);
    verify_row(20'h00003);
    for (int i = 0; i < 3; i++) program_row(rows[i]);
    for (int i = 0; i < 3; i++) verify_row(rows[i]);
    ir(jip_pkg::INS_ERASE);
    host.idle(ERASE_N);
    for (int i = 0; i < 3; i++) verify_row(rows[i] & 20'h0000f);
    check("pins still held", 32'(pin_out_o), 32'ha5);
    check("oe idle", 32'(tdo_oe_o), 32'h0);
    ir(jip_pkg::INS_DISABLE);
    host.idle(1);
    repeat (2) @(posedge clk_sys_i);
    check("isp off", 32'(isp_mode_o), 32'h0);
    check("pins back", 32'(pin_out_o), 32'h0f);
    check("init low", 32'(init_done_o), 32'h0);
    repeat (22) @(posedge clk_sys_i);
    check("init done", 32'(init_done_o), 32'h1);
    // Reset in the middle of ISP mode.
    ir(jip_pkg::INS_ENABLE);
    check("isp again", 32'(isp_mode_o), 32'h1);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    check("reset isp", 32'(isp_mode_o), 32'h0);
    check("reset oe", 32'(tdo_oe_o), 32'h0);
    check("reset pins", 32'(pin_out_o), 32'h0);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    check("pins after reset", 32'(pin_out_o), 32'h0f);
    repeat (22) @(posedge clk_sys_i);
    check("init after reset", 32'(init_done_o), 32'h1);
    finish_test();
  end
endmodule
bind jip_isp_top jip_isp_assertions #(.IO_W(IO_W), .INIT_CYCLES(INIT_CYCLES)) chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .tck_i(tck_i), .tdo_o(tdo_o),
  .tdo_oe_o(tdo_oe_o), .core_out_i(core_out_i), .pin_out_o(pin_out_o),
  .isp_mode_o(isp_mode_o), .init_done_o(init_done_o));

// file: verilog/jip_isp_top.sv
`timescale 1ns/10ps
// Contract
// - Code 01001 enters ISP, gates other commands.
// - ISP commands hold outputs at preloaded values.
// - Code 01010 erases the whole array.
// - Code 01011 programs shift data to row.
// - Code 01100 copies addressed row into shifter.
// - Code 10000 exits ISP, keeps ISP register.
// - Initialization completes within 200 us after exit.
// - Code 00010 samples pins and preloads outputs.
// - TDI sampled on rising test-clock edge.
// - TDO changes on falling edge, else tristate.
module jip_isp_top #(
  parameter int unsigned IO_W          = 8,
  parameter int unsigned ROW_W         = 16,
  parameter int unsigned ADDR_W        = 4,
  parameter int unsigned INIT_CYCLES   = jip_pkg::STARTUP_INIT_CYC
) (
  // System.
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // Test access port pins.
  input  wire logic              tck_i,
  input  wire logic              tms_i,
  input  wire logic              tdi_i,
  output logic                   tdo_o,
  output logic                   tdo_oe_o,
  // User logic and pins.
  input  wire logic [IO_W-1:0]   core_out_i,
  input  wire logic [IO_W-1:0]   pin_in_i,
  output logic      [IO_W-1:0]   pin_out_o,
  output logic                   isp_mode_o,
  output logic                   init_done_o
);
  localparam int unsigned SR_W = ROW_W + ADDR_W;
  localparam int unsigned NROW = 1 << ADDR_W;

  if (IO_W < 1 || ROW_W < 1 || ADDR_W < 1 || ADDR_W > 12 || INIT_CYCLES < 1) begin : g_bad_param
    $error("jip_isp_top: unsupported parameter values");
  end

  // Pin synchronisers and test clock edge detection.
  logic [2:0] tck_s_reg, tck_s_next;
  logic [1:0] tms_s_reg, tms_s_next, tdi_s_reg, tdi_s_next;
  logic [2*IO_W-1:0] pin_s_reg, pin_s_next;
  logic       rise, fall;
  // The sampled pin states are asynchronous and pass two flip-flops before capture.
  always_comb begin
    tck_s_next = {tck_s_reg[1:0], tck_i};
    tms_s_next = {tms_s_reg[0], tms_i};
    tdi_s_next = {tdi_s_reg[0], tdi_i};
    pin_s_next = {pin_s_reg[IO_W-1:0], pin_in_i};
  end
  assign rise = tck_s_reg[1] & ~tck_s_reg[2];
  assign fall = ~tck_s_reg[1] & tck_s_reg[2];
  wire tms = tms_s_reg[1];
  wire tdi = tdi_s_reg[1];

  // Controller, instruction and data registers.
  jip_pkg::jip_tap_e tap_reg, tap_next;
  logic [4:0]      ir_sh_reg, ir_sh_next, ir_reg, ir_next;
  logic [SR_W-1:0] isp_sh_reg, isp_sh_next;
  logic [IO_W-1:0] bs_sh_reg, bs_sh_next, bs_lat_reg, bs_lat_next;
  logic [31:0]     id_sh_reg, id_sh_next;
  logic            byp_reg, byp_next, isp_reg, isp_next;
  logic            tdo_reg, tdo_next, oe_reg, oe_next;
  logic [IO_W-1:0] pin_reg, pin_next;
  logic            done_reg, done_next;
  logic [31:0]     init_cnt_reg, init_cnt_next;
  logic [ROW_W-1:0] mem [NROW];
  logic            mem_we, mem_clr;
  logic [ADDR_W-1:0] row_addr;
  logic            isp_ins, sel_isp, sel_bs, sel_id;

  assign row_addr = isp_sh_reg[ADDR_W-1:0];
  assign isp_ins  = (ir_reg == jip_pkg::INS_ENABLE) || (ir_reg == jip_pkg::INS_ERASE) ||
                    (ir_reg == jip_pkg::INS_PROGRAM) || (ir_reg == jip_pkg::INS_VERIFY);
  assign sel_isp  = isp_ins || (ir_reg == jip_pkg::INS_DISABLE);
  assign sel_bs   = (ir_reg == jip_pkg::INS_PRELOAD) || (ir_reg == jip_pkg::INS_EXTEST) ||
                    (ir_reg == jip_pkg::INS_INTEST);
  assign sel_id   = (ir_reg == jip_pkg::INS_IDCODE);

  always_comb begin
    tap_next = tap_reg;
    if (rise) begin
      unique case (tap_reg)
        jip_pkg::TAP_RESET:  tap_next = tms ? jip_pkg::TAP_RESET  : jip_pkg::TAP_IDLE;
        jip_pkg::TAP_IDLE:   tap_next = tms ? jip_pkg::TAP_SEL_DR : jip_pkg::TAP_IDLE;
        jip_pkg::TAP_SEL_DR: tap_next = tms ? jip_pkg::TAP_SEL_IR : jip_pkg::TAP_CAP_DR;
        jip_pkg::TAP_CAP_DR: tap_next = tms ? jip_pkg::TAP_EX1_DR : jip_pkg::TAP_SH_DR;
        jip_pkg::TAP_SH_DR:  tap_next = tms ? jip_pkg::TAP_EX1_DR : jip_pkg::TAP_SH_DR;
        jip_pkg::TAP_EX1_DR: tap_next = tms ? jip_pkg::TAP_UP_DR  : jip_pkg::TAP_PA_DR;
        jip_pkg::TAP_PA_DR:  tap_next = tms ? jip_pkg::TAP_EX2_DR : jip_pkg::TAP_PA_DR;
        jip_pkg::TAP_EX2_DR: tap_next = tms ? jip_pkg::TAP_UP_DR  : jip_pkg::TAP_SH_DR;
        jip_pkg::TAP_UP_DR:  tap_next = tms ? jip_pkg::TAP_SEL_DR : jip_pkg::TAP_IDLE;
        jip_pkg::TAP_SEL_IR: tap_next = tms ? jip_pkg::TAP_RESET  : jip_pkg::TAP_CAP_IR;
        jip_pkg::TAP_CAP_IR: tap_next = tms ? jip_pkg::TAP_EX1_IR : jip_pkg::TAP_SH_IR;
        jip_pkg::TAP_SH_IR:  tap_next = tms ? jip_pkg::TAP_EX1_IR : jip_pkg::TAP_SH_IR;
        jip_pkg::TAP_EX1_IR: tap_next = tms ? jip_pkg::TAP_UP_IR  : jip_pkg::TAP_PA_IR;
        jip_pkg::TAP_PA_IR:  tap_next = tms ? jip_pkg::TAP_EX2_IR : jip_pkg::TAP_PA_IR;
        jip_pkg::TAP_EX2_IR: tap_next = tms ? jip_pkg::TAP_UP_IR  : jip_pkg::TAP_SH_IR;
        jip_pkg::TAP_UP_IR:  tap_next = tms ? jip_pkg::TAP_SEL_DR : jip_pkg::TAP_IDLE;
      endcase
    end
  end

  always_comb begin
    ir_sh_next  = ir_sh_reg;
    ir_next     = ir_reg;
    isp_sh_next = isp_sh_reg;
    bs_sh_next  = bs_sh_reg;
    bs_lat_next = bs_lat_reg;
    id_sh_next  = id_sh_reg;
    byp_next    = byp_reg;
    isp_next    = isp_reg;
    mem_we      = 1'b0;
    mem_clr     = 1'b0;
    if (rise) begin
      unique case (tap_reg)
        jip_pkg::TAP_RESET: begin
          ir_next = jip_pkg::INS_IDCODE;
        end
        jip_pkg::TAP_CAP_IR: ir_sh_next = jip_pkg::IR_CAPTURE;
        jip_pkg::TAP_SH_IR:  ir_sh_next = {tdi, ir_sh_reg[4:1]};
        jip_pkg::TAP_UP_IR: begin
          ir_next = ir_sh_reg;
          if (ir_sh_reg == jip_pkg::INS_ENABLE) begin
            isp_next = 1'b1;
          end
        end
        jip_pkg::TAP_CAP_DR: begin
          byp_next   = 1'b0;
          id_sh_next = jip_pkg::IDCODE_VAL;
          if (sel_bs) begin
            bs_sh_next = pin_s_reg[2*IO_W-1:IO_W];
          end
          if (ir_reg == jip_pkg::INS_VERIFY && isp_reg) begin
            isp_sh_next = {mem[row_addr], row_addr};
          end
        end
        jip_pkg::TAP_SH_DR: begin
          byp_next    = tdi;
          id_sh_next  = {tdi, id_sh_reg[31:1]};
          bs_sh_next  = {tdi, bs_sh_reg[IO_W-1:1]};
          isp_sh_next = {tdi, isp_sh_reg[SR_W-1:1]};
        end
        jip_pkg::TAP_UP_DR: begin
          if (sel_bs) begin
            bs_lat_next = bs_sh_reg;
          end
        end
        jip_pkg::TAP_IDLE: begin
          if (isp_reg && ir_reg == jip_pkg::INS_ERASE) begin
            mem_clr = 1'b1;
          end
          if (isp_reg && ir_reg == jip_pkg::INS_PROGRAM) begin
            mem_we = 1'b1;
          end
          if (ir_reg == jip_pkg::INS_DISABLE) begin
            isp_next = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    tdo_next = tdo_reg;
    oe_next  = oe_reg;
    if (fall) begin
      oe_next = (tap_reg == jip_pkg::TAP_SH_DR) || (tap_reg == jip_pkg::TAP_SH_IR);
      if (tap_reg == jip_pkg::TAP_SH_IR) begin
        tdo_next = ir_sh_reg[0];
      end else if (sel_isp) begin
        tdo_next = isp_sh_reg[0];
      end else if (sel_bs) begin
        tdo_next = bs_sh_reg[0];
      end else if (sel_id) begin
        tdo_next = id_sh_reg[0];
      end else begin
        tdo_next = byp_reg;
      end
    end
    pin_next      = isp_reg ? bs_lat_reg : core_out_i;
    done_next     = done_reg;
    init_cnt_next = init_cnt_reg;
    // Done drops in the same cycle as ISP mode rises, so the two are never high together.
    if (isp_reg || isp_next) begin
      done_next     = 1'b0;
      init_cnt_next = '0;
    end else if (!done_reg) begin
      if (init_cnt_reg >= INIT_CYCLES - 1) begin
        done_next = 1'b1;
      end else begin
        init_cnt_next = init_cnt_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    tck_s_reg <= tck_s_next;
    tms_s_reg <= tms_s_next;
    tdi_s_reg <= tdi_s_next;
    pin_s_reg <= pin_s_next;
    if (rst_i) begin
      tap_reg      <= jip_pkg::TAP_RESET;
      ir_sh_reg    <= '0;
      ir_reg       <= jip_pkg::INS_IDCODE;
      isp_sh_reg   <= '0;
      bs_sh_reg    <= '0;
      bs_lat_reg   <= '0;
      id_sh_reg    <= '0;
      byp_reg      <= 1'b0;
      isp_reg      <= 1'b0;
      tdo_reg      <= 1'b0;
      oe_reg       <= 1'b0;
      pin_reg      <= '0;
      done_reg     <= 1'b0;
      init_cnt_reg <= '0;
    end else begin
      tap_reg      <= tap_next;
      ir_sh_reg    <= ir_sh_next;
      ir_reg       <= ir_next;
      isp_sh_reg   <= isp_sh_next;
      bs_sh_reg    <= bs_sh_next;
      bs_lat_reg   <= bs_lat_next;
      id_sh_reg    <= id_sh_next;
      byp_reg      <= byp_next;
      isp_reg      <= isp_next;
      tdo_reg      <= tdo_next;
      oe_reg       <= oe_next;
      pin_reg      <= pin_next;
      done_reg     <= done_next;
      init_cnt_reg <= init_cnt_next;
    end
  end

  // Configuration array rows.
  for (genvar g = 0; g < NROW; g++) begin : g_row
    always_ff @(posedge clk_sys_i) begin
      if (rst_i || mem_clr) begin
        mem[g] <= '0;
      end else if (mem_we && row_addr == ADDR_W'(g)) begin
        mem[g] <= isp_sh_reg[SR_W-1:ADDR_W];
      end
    end
  end

  assign tdo_o       = tdo_reg;
  assign tdo_oe_o    = oe_reg;
  assign pin_out_o   = pin_reg;
  assign isp_mode_o  = isp_reg;
  assign init_done_o = done_reg;
endmodule

// file: verilog/jip_pkg.sv
package jip_pkg;
  // Instruction register width and codes.
  localparam int unsigned IR_W = 5;
  localparam logic [4:0] INS_EXTEST  = 5'h00;
  localparam logic [4:0] INS_IDCODE  = 5'h01;
  localparam logic [4:0] INS_PRELOAD = 5'h02;
  localparam logic [4:0] INS_INTEST  = 5'h03;
  localparam logic [4:0] INS_HIGHZ   = 5'h05;
  localparam logic [4:0] INS_ENABLE  = 5'h09;
  localparam logic [4:0] INS_ERASE   = 5'h0a;
  localparam logic [4:0] INS_PROGRAM = 5'h0b;
  localparam logic [4:0] INS_VERIFY  = 5'h0c;
  localparam logic [4:0] INS_DISABLE = 5'h10;
  localparam logic [4:0] INS_BYPASS  = 5'h1f;
  // Capture pattern of the instruction register.
  localparam logic [4:0] IR_CAPTURE  = 5'h01;
  // Arbitrary identification value.
  localparam logic [31:0] IDCODE_VAL = 32'h0000_0001;
  // Timing figures.
  localparam int unsigned CLK_MHZ            = 100;
  localparam int unsigned STARTUP_INIT_US    = 200;
  localparam int unsigned STARTUP_INIT_CYC   = STARTUP_INIT_US * CLK_MHZ;
  localparam int unsigned ERASE_PULSE_MIN_MS = 100;
  localparam int unsigned PROG_PULSE_MIN_MS  = 10;
  localparam int unsigned VERIFY_PULSE_MIN_US = 10;
  localparam int unsigned TEST_CLOCK_MAX_MHZ = 10;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE  = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR = 4'h6, TAP_EX2_DR = 4'h7,
    TAP_UP_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
    TAP_EX1_IR = 4'hc, TAP_PA_IR = 4'hd, TAP_EX2_IR = 4'he, TAP_UP_IR = 4'hf
  } jip_tap_e;
endpackage
